/* hdl/oss_pkg.sv */
// Package of constants for the oscillator source select block.
// Assumes a 32-bit APB slave with word-aligned registers.
package oss_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLK_DIV = 8'h04;
	localparam logic [7:0] ADDR_RC_TUNE = 8'h08;
	localparam logic [7:0] ADDR_CFG_STAT = 8'h0C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CUR_SRC_LSB = 12;
	localparam int NEW_SRC_LSB = 8;
	localparam int SEL_LOCK_BIT = 7;
	localparam int PLL_LOCK_BIT = 5;
	localparam int FAIL_BIT = 3;
	localparam int DRIVE_BIT = 2;
	localparam int SEC_EN_BIT = 1;
	localparam int SW_EN_BIT = 0;
	localparam int POSTSCALE_LSB = 8;
	localparam int TUNE_W = 6;

	// ----------------------------------------
	// Source codes
	// ----------------------------------------
	localparam logic [2:0] SRC_FRC_DIV = 3'h7;
	localparam logic [2:0] SRC_SLOW_FRC_DIV = 3'h6;
	localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] SRC_PRIMARY = 3'h2;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_FRC = 3'h0;

	// ----------------------------------------
	// Primary mode codes
	// ----------------------------------------
	localparam logic [1:0] PMODE_HS = 2'h2;
	localparam logic [1:0] PMODE_XT = 2'h1;
	localparam logic [1:0] PMODE_EC = 2'h0;
	localparam logic [1:0] PMODE_INTERNAL = 2'h3;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [2:0] POSTSCALE_RST = 3'h1;
	localparam logic [2:0] SRC_ERASED = 3'h7;
	localparam logic [1:0] SWMON_ERASED = 2'h3;
	localparam logic [1:0] RANGE_ERASED = 2'h3;
	localparam int SETTLE_EDGES = 10;
	localparam logic [1:0] CFG_LOAD_AT = 2'h2;

	function automatic logic oss_is_pll(input logic [2:0] src);
		return (src == SRC_PRIMARY_PLL) || (src == SRC_FRC_PLL);
	endfunction : oss_is_pll

endpackage : oss_pkg

/* hdl/oss_osc_select.sv */
// Oscillator source selection, switching and control registers.
// Assumes oscillator status inputs arrive asynchronously and that
// configuration straps are stable while the block runs.
//
// Operation
// [RQ1] System clock from exactly one of four sources
// [RQ2] Multiplier only for primary and fast RC
// [RQ3] Instruction clock is processor clock over two
// [RQ4] Instruction clock driven on output pin
// [RQ5] Power-on source from two configuration fields
// [RQ6] Erased configuration starts fast RC postscaled
// [RQ7] External clock range field, erased above 8MHz
// [RQ8] Switching allowed only when upper bit zero
// [RQ9] Fail monitor enabled only when field 00
// [RQ10] Eight source selection codes as listed
// [RQ11] Primary mode codes HS, XT, EC, internal
// [RQ12] Current source field read-only, hardware updated
// [RQ13] New source field loads from configuration
// [RQ14] Multiplier lock reads zero when switching, unused
// [RQ15] Selection lock resets zero, software sets only
// [RQ16] Clock fail flag hardware set, software clears
// [RQ17] Drive strength ignored for digital input
// [RQ18] Configuration bit picks secondary power variant
// [RQ19] Tune register adjusts fast RC frequency
// [RQ20] Postscaler divides fast RC clock
// [RQ21] Switch enable starts switch, cleared when done
// [RQ22] Same source request aborts, clears enable
// [RQ23] Wait ten new-source edges before transfer
// [RQ24] Switch enable held zero when switching disabled
// [RQ25] Current source updated at transfer only
// [RQ26] Unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module oss_osc_select #(
	parameter int SETTLE = oss_pkg::SETTLE_EDGES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [1:0] i_primary_mode_cfg,
	input wire logic [2:0] i_initial_source_cfg,
	input wire logic [1:0] i_ext_clock_range_cfg,
	input wire logic [1:0] i_switch_monitor_cfg,
	input wire logic i_secondary_power_select_cfg,
	input wire logic i_secondary_input_kind_cfg,
	input wire logic i_osc_out_pin_function_cfg,
	input wire logic i_new_src_clk,
	input wire logic i_src_ready,
	input wire logic i_pll_locked,
	input wire logic i_clock_fail,
	output logic [2:0] o_sys_src,
	output logic [2:0] o_request_src,
	output logic o_pll_en,
	output logic [2:0] o_postscale_sel,
	output logic [5:0] o_rc_tune,
	output logic o_secondary_en,
	output logic o_secondary_high_drive,
	output logic o_secondary_low_power,
	output logic o_fail_monitor_en,
	output logic [1:0] o_primary_mode,
	output logic [1:0] o_ext_range,
	output logic o_instr_clk,
	output logic o_osc_out,
	output logic o_osc_out_oe
);

	if (SETTLE < 1 || SETTLE > 255) begin : g_settle_check
		$error("SETTLE must lie in 1..255");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_SETTLE = 3'b100
	} oss_state_e;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int SW = 16;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic new_clk_d_r;
	logic fail_d_r;
	wire logic [SW-1:0] raw_in = {i_primary_mode_cfg,
		i_initial_source_cfg, i_ext_clock_range_cfg,
		i_switch_monitor_cfg, i_secondary_power_select_cfg,
		i_secondary_input_kind_cfg, i_osc_out_pin_function_cfg,
		i_new_src_clk, i_src_ready, i_pll_locked, i_clock_fail};

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			new_clk_d_r <= 1'b0;
			fail_d_r <= 1'b0;
		end else if (i_clk_en) begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			new_clk_d_r <= sync2_r[3];
			fail_d_r <= sync2_r[0];
		end
	end

	wire logic new_clk_rise = sync2_r[3] & ~new_clk_d_r;
	wire logic src_ready_s = sync2_r[2];
	wire logic pll_lock_s = sync2_r[1];
	wire logic fail_rise = sync2_r[0] & ~fail_d_r;

	// ----------------------------------------
	// Configuration capture after reset
	// ----------------------------------------
	logic [1:0] cfg_cnt_r;
	logic [1:0] pmode_r;
	logic [1:0] range_r;
	logic [1:0] swmon_r;
	logic sec_pwr_r;
	logic sec_kind_r;
	logic out_fn_r;
	wire logic cfg_load = (cfg_cnt_r == oss_pkg::CFG_LOAD_AT);
	wire logic sw_allowed = ~swmon_r[1];

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_cnt_r <= 2'h0;
		end else if (i_clk_en && cfg_cnt_r != 2'h3) begin
			cfg_cnt_r <= cfg_cnt_r + 2'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pmode_r <= oss_pkg::PMODE_INTERNAL;
			range_r <= oss_pkg::RANGE_ERASED;
			swmon_r <= oss_pkg::SWMON_ERASED;
			sec_pwr_r <= 1'b1;
			sec_kind_r <= 1'b1;
			out_fn_r <= 1'b1;
		end else if (i_clk_en && cfg_load) begin
			pmode_r <= sync2_r[15:14]; // RQ5 RQ11
			range_r <= sync2_r[10:9]; // RQ7
			swmon_r <= sync2_r[8:7];
			sec_pwr_r <= sync2_r[6]; // RQ18
			sec_kind_r <= sync2_r[5];
			out_fn_r <= sync2_r[4];
		end
	end

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	logic pready_r;
	wire logic acc = i_psel & i_penable & pready_r & i_clk_en;
	wire logic wr = acc & i_pwrite;
	wire logic wr_ctrl = wr && i_paddr == oss_pkg::ADDR_OSC_CTRL;
	wire logic wr_div = wr && i_paddr == oss_pkg::ADDR_CLK_DIV;
	wire logic wr_tune = wr && i_paddr == oss_pkg::ADDR_RC_TUNE;

	// ----------------------------------------
	// Switch sequencer
	// ----------------------------------------
	oss_state_e state_r;
	logic [2:0] cur_src_r;
	logic [2:0] new_src_r;
	logic [2:0] target_r;
	logic [7:0] edge_cnt_r;
	logic sw_en_r;
	logic sel_lock_r;
	logic pll_lock_r;
	logic fail_r;
	logic drive_r;
	logic sec_en_r;
	logic [2:0] postscale_r;
	logic [5:0] tune_r;
	wire logic redundant = state_r == ST_IDLE && sw_en_r &&
		new_src_r == cur_src_r;
	wire logic start = state_r == ST_IDLE && sw_en_r &&
		new_src_r != cur_src_r;
	wire logic settle_end = state_r == ST_SETTLE && new_clk_rise &&
		edge_cnt_r == 8'(SETTLE - 1);
	wire logic src_up = src_ready_s &&
		(!oss_pkg::oss_is_pll(target_r) || pll_lock_s); // RQ2

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= ST_IDLE;
			edge_cnt_r <= 8'h00;
			target_r <= oss_pkg::SRC_ERASED;
		end else if (i_clk_en) begin
			case (state_r)
				ST_IDLE: begin
					edge_cnt_r <= 8'h00;
					if (start) begin
						target_r <= new_src_r;
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (src_up)
						state_r <= ST_SETTLE;
				end
				ST_SETTLE: begin
					if (settle_end) // RQ23
						state_r <= ST_IDLE;
					else if (new_clk_rise)
						edge_cnt_r <= edge_cnt_r + 8'h01;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cur_src_r <= oss_pkg::SRC_ERASED; // RQ6
		end else if (i_clk_en) begin
			if (cfg_load)
				cur_src_r <= sync2_r[13:11]; // RQ5
			else if (settle_end)
				cur_src_r <= target_r; // RQ12 RQ25 RQ1
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			new_src_r <= oss_pkg::SRC_ERASED;
		end else if (i_clk_en) begin
			if (cfg_load)
				new_src_r <= sync2_r[13:11]; // RQ13
			else if (wr_ctrl && !sel_lock_r)
				new_src_r <= i_pwdata[oss_pkg::NEW_SRC_LSB +: 3];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sw_en_r <= 1'b0;
		end else if (i_clk_en) begin
			if (!sw_allowed)
				sw_en_r <= 1'b0; // RQ8 RQ24
			else if (redundant || settle_end)
				sw_en_r <= 1'b0; // RQ21 RQ22
			else if (wr_ctrl && !sel_lock_r && state_r == ST_IDLE &&
				i_pwdata[oss_pkg::SW_EN_BIT])
				sw_en_r <= 1'b1; // RQ21
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_lock_r <= 1'b0;
		end else if (i_clk_en) begin
			if (!sw_allowed)
				sel_lock_r <= 1'b0;
			else if (wr_ctrl && i_pwdata[oss_pkg::SEL_LOCK_BIT])
				sel_lock_r <= 1'b1; // RQ15
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pll_lock_r <= 1'b0;
		end else if (i_clk_en) begin
			pll_lock_r <= state_r == ST_IDLE && !start &&
				oss_pkg::oss_is_pll(cur_src_r) && pll_lock_s; // RQ14
		end
	end

	// Hardware set wins over a clearing write in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fail_r <= 1'b0;
		end else if (i_clk_en) begin
			if (fail_rise && o_fail_monitor_en)
				fail_r <= 1'b1; // RQ16
			else if (start)
				fail_r <= 1'b0;
			else if (wr_ctrl && !i_pwdata[oss_pkg::FAIL_BIT])
				fail_r <= 1'b0; // RQ16
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			drive_r <= 1'b0;
			sec_en_r <= 1'b0;
			postscale_r <= oss_pkg::POSTSCALE_RST;
			tune_r <= '0;
		end else if (i_clk_en) begin
			if (wr_ctrl) begin
				drive_r <= i_pwdata[oss_pkg::DRIVE_BIT];
				sec_en_r <= i_pwdata[oss_pkg::SEC_EN_BIT];
			end
			if (wr_div) // RQ20
				postscale_r <= i_pwdata[oss_pkg::POSTSCALE_LSB +: 3];
			if (wr_tune) // RQ19
				tune_r <= i_pwdata[oss_pkg::TUNE_W-1:0];
		end
	end

	// ----------------------------------------
	// Read data and bus answer
	// ----------------------------------------
	logic [31:0] rd_nxt;
	logic err_nxt;

	always_comb begin
		rd_nxt = 32'h0000_0000; // RQ26
		err_nxt = 1'b0;
		if (i_paddr == oss_pkg::ADDR_OSC_CTRL) begin
			rd_nxt[oss_pkg::CUR_SRC_LSB +: 3] = cur_src_r; // RQ12
			rd_nxt[oss_pkg::NEW_SRC_LSB +: 3] = new_src_r;
			rd_nxt[oss_pkg::SEL_LOCK_BIT] = sel_lock_r;
			rd_nxt[oss_pkg::PLL_LOCK_BIT] = pll_lock_r;
			rd_nxt[oss_pkg::FAIL_BIT] = fail_r;
			rd_nxt[oss_pkg::DRIVE_BIT] = drive_r;
			rd_nxt[oss_pkg::SEC_EN_BIT] = sec_en_r;
			rd_nxt[oss_pkg::SW_EN_BIT] = sw_en_r;
		end else if (i_paddr == oss_pkg::ADDR_CLK_DIV) begin
			rd_nxt[oss_pkg::POSTSCALE_LSB +: 3] = postscale_r;
		end else if (i_paddr == oss_pkg::ADDR_RC_TUNE) begin
			rd_nxt[oss_pkg::TUNE_W-1:0] = tune_r;
		end else if (i_paddr == oss_pkg::ADDR_CFG_STAT) begin
			rd_nxt[8:0] = {out_fn_r, sec_kind_r, sec_pwr_r,
				swmon_r, range_r, pmode_r};
		end else begin
			err_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pready_r <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (i_clk_en) begin
			pready_r <= i_psel & ~i_penable;
			if (i_psel && !i_penable) begin
				o_prdata <= i_pwrite ? 32'h0000_0000 : rd_nxt;
				o_pslverr <= err_nxt;
			end
		end
	end

	assign o_pready = pready_r;

	// ----------------------------------------
	// Clock outputs and steering
	// ----------------------------------------
	wire logic primary_xtal = (cur_src_r == oss_pkg::SRC_PRIMARY || // RQ10
		cur_src_r == oss_pkg::SRC_PRIMARY_PLL) &&
		pmode_r != oss_pkg::PMODE_EC;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_instr_clk <= 1'b0;
			o_osc_out <= 1'b0;
			o_osc_out_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_instr_clk <= ~o_instr_clk; // RQ3
			o_osc_out <= ~o_instr_clk; // RQ4
			o_osc_out_oe <= out_fn_r && !primary_xtal; // RQ4
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pll_en <= 1'b0;
			o_request_src <= oss_pkg::SRC_ERASED;
			o_secondary_high_drive <= 1'b0;
			o_fail_monitor_en <= 1'b0;
		end else if (i_clk_en) begin
			o_pll_en <= oss_pkg::oss_is_pll(cur_src_r) ||
				(state_r != ST_IDLE &&
				oss_pkg::oss_is_pll(target_r)); // RQ2
			o_request_src <= state_r == ST_IDLE ? cur_src_r : target_r;
			o_secondary_high_drive <= drive_r & sec_kind_r; // RQ17
			o_fail_monitor_en <= swmon_r == 2'h0; // RQ9
		end
	end

	assign o_sys_src = cur_src_r;
	assign o_postscale_sel = postscale_r;
	assign o_rc_tune = tune_r;
	assign o_secondary_en = sec_en_r;
	assign o_secondary_low_power = sec_pwr_r;
	assign o_primary_mode = pmode_r;
	assign o_ext_range = range_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_redundant_abort: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) i_clk_en && redundant && sw_allowed
		|=> !sw_en_r && state_r == ST_IDLE) // RQ22
		else $error("redundant switch not aborted");

	a_swen_disabled: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) !sw_allowed && $past(!sw_allowed)
		|-> !sw_en_r) // RQ24
		else $error("switch enable set while disabled");

	a_cur_src_move: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) $past(cfg_cnt_r) == 2'h3 &&
		$changed(cur_src_r) |-> $past(settle_end)) // RQ25
		else $error("current source changed outside transfer");

	a_pll_lock_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) $past(state_r) != ST_IDLE ||
		!oss_pkg::oss_is_pll($past(cur_src_r)) |-> !pll_lock_r) // RQ14
		else $error("lock status high without multiplier");

	a_fail_set_wins: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) i_clk_en && fail_rise &&
		o_fail_monitor_en |=> fail_r) // RQ16
		else $error("clock fail event lost");

	a_lock_set_only: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) sel_lock_r && sw_allowed
		|=> sel_lock_r) // RQ15
		else $error("selection lock cleared while allowed");

	a_instr_div: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) i_clk_en ##1 i_clk_en
		|-> o_instr_clk != $past(o_instr_clk)) // RQ3
		else $error("instruction clock not divided by two");

	a_settle_count: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) i_clk_en && state_r == ST_SETTLE &&
		new_clk_rise && edge_cnt_r != 8'(SETTLE - 1)
		|=> state_r == ST_SETTLE &&
		edge_cnt_r == $past(edge_cnt_r) + 8'h01) // RQ23
		else $error("transfer before settle edges");

	a_swen_clear_done: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn) i_clk_en && settle_end
		|=> !sw_en_r && cur_src_r == $past(target_r)) // RQ21
		else $error("switch completion not reported");

endmodule : oss_osc_select

/* testbench/tb_oss_osc_select.sv */
// Self-checking bench for the oscillator source select block.
// Assumes the block is the only APB slave and the bench plays every
// oscillator, strap and monitor input itself.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_oss_osc_select;
	localparam int SETTLE = 10;
	logic sys_clk, resetn, clk_en, psel, penable, pwrite, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, new_clk, src_ready, pll_locked, clock_fail;
	logic [1:0] pmode_cfg, range_cfg, swmon_cfg;
	logic [2:0] src_cfg;
	logic pwr_cfg, kind_cfg, fn_cfg;
	logic [2:0] o_sys_src, o_request_src, o_postscale_sel;
	logic o_pll_en, o_secondary_en, o_secondary_high_drive;
	logic o_secondary_low_power, o_fail_monitor_en, o_instr_clk;
	logic o_osc_out, o_osc_out_oe;
	logic [5:0] o_rc_tune;
	logic [1:0] o_primary_mode, o_ext_range;
	int n_fail, n_tests;
	logic [31:0] q;
	logic t;

	oss_osc_select #(.SETTLE(SETTLE)) i_oss_osc_select (
		.i_sys_clk(sys_clk), .i_resetn(resetn), .i_clk_en(clk_en),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_primary_mode_cfg(pmode_cfg), .i_initial_source_cfg(src_cfg),
		.i_ext_clock_range_cfg(range_cfg), .i_switch_monitor_cfg(swmon_cfg),
		.i_secondary_power_select_cfg(pwr_cfg),
		.i_secondary_input_kind_cfg(kind_cfg),
		.i_osc_out_pin_function_cfg(fn_cfg), .i_new_src_clk(new_clk),
		.i_src_ready(src_ready), .i_pll_locked(pll_locked),
		.i_clock_fail(clock_fail), .o_sys_src(o_sys_src),
		.o_request_src(o_request_src), .o_pll_en(o_pll_en),
		.o_postscale_sel(o_postscale_sel), .o_rc_tune(o_rc_tune),
		.o_secondary_en(o_secondary_en),
		.o_secondary_high_drive(o_secondary_high_drive),
		.o_secondary_low_power(o_secondary_low_power),
		.o_fail_monitor_en(o_fail_monitor_en),
		.o_primary_mode(o_primary_mode), .o_ext_range(o_ext_range),
		.o_instr_clk(o_instr_clk), .o_osc_out(o_osc_out),
		.o_osc_out_oe(o_osc_out_oe)
	);

	always #4 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	function automatic logic [31:0] exp_osc(input logic [2:0] cur, nw,
		input logic lk, pl, cf);
		return {17'h0, cur, 1'b0, nw, lk, 1'b0, pl, 1'b0, cf, 3'h0};
	endfunction : exp_osc

	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			test_done();
		end
		r = prdata;
		t = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic edges(input int n);
		repeat (n) begin
			new_clk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			new_clk <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask : edges

	task automatic do_reset(input logic [1:0] pm, input logic [2:0] src,
		input logic [1:0] rng, swm, input logic pwr, kind, fn);
		resetn <= 1'b0;
		pmode_cfg <= pm;
		src_cfg <= src;
		range_cfg <= rng;
		swmon_cfg <= swm;
		pwr_cfg <= pwr;
		kind_cfg <= kind;
		fn_cfg <= fn;
		repeat (5) @(posedge sys_clk);
		`CHK(o_sys_src, 3'h7)
		`CHK(o_postscale_sel, 3'h1)
		resetn <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask : do_reset

	// Full switch to code c, counting new-source edges
	task automatic sw(input logic [2:0] c);
		logic [2:0] old;
		logic [31:0] r;
		logic pl;
		int n;
		old = o_sys_src;
		pl = (c == 3'h1) || (c == 3'h3);
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, {21'h0, c, 8'h00}, r);
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, {21'h0, c, 8'h01}, r);
		repeat (4) @(posedge sys_clk);
		`CHK(o_request_src, c)
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, r);
		`CHK(r, exp_osc(old, c, 1'b0, 1'b0, 1'b0) | 32'h1)
		edges(SETTLE - 1);
		repeat (6) @(posedge sys_clk);
		`CHK(o_sys_src, old)
		edges(1);
		n = 0;
		while (o_sys_src !== c && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(o_sys_src, c)
		if (n >= 20)
			test_done();
		repeat (2) @(posedge sys_clk);
		`CHK(o_pll_en, pl)
		`CHK(o_osc_out_oe, !(c == 3'h2 || c == 3'h3))
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, r);
		`CHK(r, exp_osc(c, c, 1'b0, pl, 1'b0))
	endtask : sw

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{new_clk, clock_fail} = 2'h0;
		src_ready = 1'b1;
		pll_locked = 1'b1;
		{pmode_cfg, range_cfg, swmon_cfg, src_cfg} = 9'h1FF;
		{pwr_cfg, kind_cfg, fn_cfg} = 3'h0;
		n_fail = 0;
		n_tests = 0;
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			do_reset(i[1:0], 3'h7, i[1:0], i[1:0], i[0], i[1], 1'b0);
			`CHK(o_primary_mode, i[1:0])
			`CHK(o_ext_range, i[1:0])
			`CHK(o_fail_monitor_en, i == 0)
			`CHK(o_secondary_low_power, i[0])
			apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
			`CHK(q, exp_osc(3'h7, 3'h7, 1'b0, 1'b0, 1'b0))
			apb(1'b0, oss_pkg::ADDR_CLK_DIV, 32'h0, q);
			`CHK(q, 32'h0000_0100)
			apb(1'b0, oss_pkg::ADDR_RC_TUNE, 32'h0, q);
			`CHK(q, 32'h0)
			apb(1'b0, 8'h10, 32'h0, q);
			`CHK({t, q}, 33'h1_0000_0000)
			apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0007, q);
			repeat (4) @(posedge sys_clk);
			apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
			`CHK(q[2], 1'b1)
			`CHK({q[1], o_secondary_en}, 2'h3)
			`CHK(q[0], !i[1])
			`CHK(o_secondary_high_drive, i[1])
			`CHK(o_sys_src, 3'h7)
		end
		// Switching and monitor enabled, fast RC start, HS primary
		do_reset(oss_pkg::PMODE_HS, 3'h0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b1);
		`CHK(o_sys_src, 3'h0)
		`CHK(o_osc_out_oe, 1'b1)
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q, exp_osc(3'h0, 3'h0, 1'b0, 1'b0, 1'b0))
		apb(1'b0, oss_pkg::ADDR_CFG_STAT, 32'h0, q);
		`CHK(q, 32'h0000_0106)
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0008, q);
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q[3], 1'b0)
		clock_fail <= 1'b1;
		repeat (4) @(posedge sys_clk);
		clock_fail <= 1'b0;
		repeat (2) @(posedge sys_clk);
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0008, q);
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q[3], 1'b1)
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'hFFFF_F850, q);
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q, exp_osc(3'h0, 3'h0, 1'b0, 1'b0, 1'b0))
		apb(1'b1, oss_pkg::ADDR_RC_TUNE, 32'hFFFF_FFFF, q);
		apb(1'b0, oss_pkg::ADDR_RC_TUNE, 32'h0, q);
		`CHK({q, o_rc_tune}, {32'h0000_003F, 6'h3F})
		apb(1'b1, oss_pkg::ADDR_CLK_DIV, 32'hFFFF_FFFF, q);
		apb(1'b0, oss_pkg::ADDR_CLK_DIV, 32'h0, q);
		`CHK({q, o_postscale_sel}, {32'h0000_0700, 3'h7})
		for (int c = 7; c >= 0; c--) begin
			sw(c[2:0]);
		end
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0001, q);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q, exp_osc(3'h0, 3'h0, 1'b0, 1'b0, 1'b0))
		`CHK(o_request_src, 3'h0)
		t = o_instr_clk;
		repeat (3) begin
			@(posedge sys_clk);
			`CHK(o_instr_clk, ~t)
			`CHK(o_osc_out, ~t)
			t = o_instr_clk;
		end
		@(posedge sys_clk);
		// Clock enable low must freeze the divider
		clk_en <= 1'b0;
		repeat (2) @(posedge sys_clk);
		t = o_instr_clk;
		repeat (3) @(posedge sys_clk);
		`CHK(o_instr_clk, t)
		clk_en <= 1'b1;
		@(posedge sys_clk);
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0080, q);
		apb(1'b1, oss_pkg::ADDR_OSC_CTRL, 32'h0000_0301, q);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, oss_pkg::ADDR_OSC_CTRL, 32'h0, q);
		`CHK(q, exp_osc(3'h0, 3'h0, 1'b1, 1'b0, 1'b0))
		test_done();
	end
endmodule : tb_oss_osc_select
